// ---- rx_pkg.sv ----
// Shared constants and types for the character search receiver
// Summary of operation
// R1 - Internal search: holding register mirrors shift register
// R2 - Match on search: freeze holding, raise match
// R3 - Synced: transfer at last bit, set received
// R4 - Search line falling: lose sync, go transparent
// R5 - External mode, search low: holding stays transparent
// R6 - External search rising: frame, transfer, set received
// R7 - Match flag compares; async updates at stop
// R8 - Shift one bit per receive clock fall
// R9 - Rate select bits set sampling rate
// R10 - Sender places clock fall mid bit
// R11 - Master clear idles logic, holding all ones
// R12 - Master clear keeps control register
// R13 - Control latches load while strobe, enable low
// R14 - Chip disable high blocks control strobe
// R15 - Host pulses strobe or ties it low
// R16 - Match latches load while strobe, enable low
// R17 - Frame by length, parity and stop bits
// R18 - Idle serial line is held high
// R19 - Search line rising starts internal search
// R20 - Received clear low clears received flag
// R21 - Transfer while received set raises overrun
// R22 - Stop bit low raises framing error
// R23 - Single clock, pins synchronised, clear asserted
// R24 - Search line edges detected once each
package rx_pkg;

  localparam int DATA_W = 8;
  localparam int SR_W = 9;
  localparam logic [3:0] SR_LEN = 4'h9;
  localparam logic [3:0] BASE_LEN = 4'h5;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [DATA_W-1:0] HOLD_RESET = 8'hFF;
  localparam logic [DATA_W-1:0] MATCH_RESET = 8'h00;
  localparam logic [SR_W-1:0] SR_RESET = 9'h1FF;
  localparam logic [SR_W-1:0] SR_ONE = 9'h001;
  localparam logic [6:0] TICK_ONE = 7'h01;
  localparam logic [6:0] DIV_X1 = 7'h01;
  localparam logic [6:0] DIV_X16 = 7'h10;
  localparam logic [6:0] DIV_X32 = 7'h20;
  localparam logic [6:0] DIV_X64 = 7'h40;
  localparam int SYNC_MODE_BIT = 2;
  localparam int EXT_SYNC_BIT = 0;

  typedef enum logic [1:0] {
    A_IDLE = 2'b00,
    A_START = 2'b01,
    A_DATA = 2'b10,
    A_STOP = 2'b11
  } async_state_t;

  typedef struct packed {
    logic evenOddSelect;
    logic parityInhibit;
    logic [2:0] rateModeSel;
    logic [1:0] wordLenSel;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = 7'h00;

  typedef struct packed {
    logic charReceived;
    logic matchFound;
    logic parityErr;
    logic framingErr;
    logic overrun;
  } flags_t;

  localparam flags_t FLAGS_RESET = 5'h00;

endpackage : rx_pkg

// ---- pin_sync.sv ----
// Three-stage pin synchroniser with agreement qualifier
module pin_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [W-1:0] pinIn,
  input wire logic [W-1:0] resetValue,
  output logic [W-1:0] pinOut
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_state_t;

  sync_state_t s;
  sync_state_t next_s;

  always_comb begin
    next_s = s;
    next_s.s1 = pinIn;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    // Bit counts only once stages two and three agree
    for (int i = 0; i < W; i++) begin
      if (s.s2[i] == s.s3[i]) begin
        next_s.q[i] = s.s3[i];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pinOut = s.q ^ resetValue;
endmodule : pin_sync

// ---- sync_char_search_receiver.sv ----
// Character sync search receiver with control and match latches
module sync_char_search_receiver (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic master_clear,
  input wire logic chip_disable,
  input wire logic rx_shift_clock,
  input wire logic serial_in,
  input wire logic ctrl_load_strobe_n,
  input wire rx_pkg::ctrl_t ctrlIn,
  input wire logic match_load_strobe_n,
  input wire logic [rx_pkg::DATA_W-1:0] matchIn,
  input wire logic char_received_clear_n,
  input wire logic status_flag_clear_n,
  input wire logic frameErrSyncSearchIn,
  output logic frameErrSyncSearchOut,
  output logic frameErrSyncSearchOe,
  output logic [rx_pkg::DATA_W-1:0] holdData,
  output logic holdOutEnable,
  output rx_pkg::flags_t flags
);
  import rx_pkg::*;

  typedef struct packed {
    ctrl_t ctrl;
    logic [DATA_W-1:0] match;
    logic [DATA_W-1:0] hold;
    logic [SR_W-1:0] sr;
    flags_t flags;
    logic synced;
    logic searching;
    async_state_t ast;
    logic [3:0] bitCnt;
    logic [6:0] tick;
    logic prevRxClk;
    logic prevSearch;
  } state_t;

  localparam int PIN_W = 24;

  state_t s;
  state_t next_s;
  logic [PIN_W-1:0] pinRaw;
  logic [PIN_W-1:0] pinQ;
  logic [PIN_W-1:0] pinIdle;

  logic mcQ, disableQ, rxClkQ, serialQ, ctrlLoadQ, matchLoadQ, recvClearQ;
  logic statusClearQ, searchQ;
  ctrl_t ctrlQ;
  logic [DATA_W-1:0] matchQ;

  // ==========================================================
  // Pin synchronisation
  assign pinRaw = {master_clear, chip_disable, rx_shift_clock, serial_in,
                   ctrl_load_strobe_n, match_load_strobe_n,
                   char_received_clear_n, status_flag_clear_n,
                   frameErrSyncSearchIn, ctrlIn, matchIn};
  // Inverted so strobes, clears and idle line start high
  assign pinIdle = {1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1,
                    1'b0, 7'h00, 8'h00};

  pin_sync #(.W(PIN_W)) u_pin_sync ( // R23
    .ref_clk(ref_clk),
    .rstn(rstn),
    .pinIn(pinRaw ^ pinIdle),
    .resetValue(pinIdle),
    .pinOut(pinQ)
  );

  assign {mcQ, disableQ, rxClkQ, serialQ, ctrlLoadQ, matchLoadQ, recvClearQ,
          statusClearQ, searchQ, ctrlQ, matchQ} = pinQ;

  // ==========================================================
  // Receive logic
  logic rxFall, searchRise, searchFall, isSync, isExt, shift, transfer;
  logic stopBad, parBit, parErr;
  logic [3:0] dataLen, frameLen;
  logic [SR_W-1:0] newSr, frame, dataMask;
  logic [DATA_W-1:0] data;
  logic [6:0] divisor, half;

  always_comb begin
    next_s = s;
    rxFall = s.prevRxClk & ~rxClkQ;
    searchRise = ~s.prevSearch & searchQ; // R24
    searchFall = s.prevSearch & ~searchQ; // R24
    next_s.prevRxClk = rxClkQ;
    next_s.prevSearch = searchQ;
    isSync = s.ctrl.rateModeSel[SYNC_MODE_BIT];
    isExt = s.ctrl.rateModeSel[EXT_SYNC_BIT];
    dataLen = BASE_LEN + {2'b00, s.ctrl.wordLenSel}; // R17
    frameLen = dataLen + {3'b000, ~s.ctrl.parityInhibit}; // R17
    case (s.ctrl.rateModeSel[1:0]) // R9
      2'b00: divisor = DIV_X1;
      2'b01: divisor = DIV_X16;
      2'b10: divisor = DIV_X32;
      default: divisor = DIV_X64;
    endcase
    half = divisor >> 1;
    shift = 1'b0;
    transfer = 1'b0;
    stopBad = 1'b0;

    // Control and match latches, transparent while enabled
    if (!disableQ && !ctrlLoadQ) begin // R13 R14
      next_s.ctrl = ctrlQ;
    end
    if (!disableQ && !matchLoadQ) begin // R16
      next_s.match = matchQ;
    end
    // Clears first so that a same-cycle set wins
    if (!disableQ && !recvClearQ) begin
      next_s.flags.charReceived = 1'b0; // R20
    end
    if (!disableQ && !statusClearQ) begin
      next_s.flags.parityErr = 1'b0;
      next_s.flags.framingErr = 1'b0;
      next_s.flags.overrun = 1'b0;
    end

    if (isSync) begin
      shift = rxFall; // R8
      next_s.ast = A_IDLE;
    end else begin
      next_s.synced = 1'b0;
      next_s.searching = 1'b0;
      if (rxFall) begin
        next_s.tick = s.tick + TICK_ONE;
        case (s.ast)
          A_IDLE: begin
            next_s.tick = '0;
            next_s.bitCnt = '0;
            if (!serialQ) begin
              if (divisor == DIV_X1) begin
                next_s.ast = A_DATA;
              end else begin
                next_s.ast = A_START;
              end
            end
          end
          A_START: begin
            if (s.tick == half - TICK_ONE) begin
              next_s.tick = '0;
              next_s.ast = serialQ ? A_IDLE : A_DATA;
            end
          end
          A_DATA: begin
            if (s.tick == divisor - TICK_ONE) begin
              next_s.tick = '0;
              shift = 1'b1; // R17
              next_s.bitCnt = s.bitCnt + CNT_ONE;
              if (s.bitCnt == frameLen - CNT_ONE) begin
                next_s.ast = A_STOP;
              end
            end
          end
          A_STOP: begin
            if (s.tick == divisor - TICK_ONE) begin
              transfer = 1'b1; // R7
              stopBad = ~serialQ; // R22
              next_s.ast = A_IDLE;
            end
          end
          default: next_s.ast = A_IDLE;
        endcase
      end
    end

    newSr = shift ? {serialQ, s.sr[SR_W-1:1]} : s.sr;
    frame = newSr >> (SR_LEN - frameLen);
    dataMask = (SR_ONE << dataLen) - SR_ONE;
    data = DATA_W'(frame & dataMask);
    parBit = frame[dataLen];
    parErr = ~s.ctrl.parityInhibit &
             (^data ^ parBit ^ ~s.ctrl.evenOddSelect);
    next_s.sr = newSr;

    if (isSync) begin
      if (isExt) begin
        if (searchRise) begin
          next_s.synced = 1'b1; // R6
          next_s.bitCnt = '0;
        end
        if (searchFall) begin
          next_s.synced = 1'b0; // R4
        end
      end else begin
        if (searchRise) begin
          next_s.searching = 1'b1; // R19
          next_s.synced = 1'b0;
        end
        if (searchFall) begin
          next_s.searching = 1'b0; // R4
          next_s.synced = 1'b0;
        end
      end
      if (shift && s.synced && !searchFall) begin
        next_s.bitCnt = s.bitCnt + CNT_ONE;
        if (s.bitCnt == frameLen - CNT_ONE) begin
          next_s.bitCnt = '0;
          transfer = 1'b1; // R3 R6
        end
      end else if (shift && !s.synced) begin
        next_s.hold = data; // R1 R5
        if (!isExt && s.searching && data == s.match[DATA_W-1:0]) begin
          next_s.synced = 1'b1; // R2
          next_s.bitCnt = '0;
          next_s.flags.matchFound = 1'b1; // R2 R7
        end
      end
    end

    if (transfer) begin
      next_s.hold = data;
      next_s.flags.charReceived = 1'b1; // R3
      next_s.flags.matchFound = (data == s.match); // R7
      if (s.flags.charReceived) begin
        next_s.flags.overrun = 1'b1; // R21
      end
      if (parErr) begin
        next_s.flags.parityErr = 1'b1;
      end
      if (stopBad) begin
        next_s.flags.framingErr = 1'b1; // R22
      end
    end

    // Master clear resets all but the control latches, prevRxClk and prevSearch
    if (mcQ) begin // R11 R23
      next_s.match = MATCH_RESET;
      next_s.hold = HOLD_RESET;
      next_s.sr = SR_RESET;
      next_s.flags = FLAGS_RESET;
      next_s.synced = 1'b0;
      next_s.searching = 1'b0;
      next_s.ast = A_IDLE;
      next_s.bitCnt = '0;
      next_s.tick = '0;
      next_s.ctrl = s.ctrl; // R12
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s <= '{ctrl: CTRL_RESET, match: MATCH_RESET, hold: HOLD_RESET,
             sr: SR_RESET, flags: FLAGS_RESET, synced: 1'b0,
             searching: 1'b0, ast: A_IDLE, bitCnt: '0, tick: '0,
             prevRxClk: 1'b1, prevSearch: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Outputs
  assign holdData = s.hold;
  assign holdOutEnable = ~disableQ;
  assign flags = s.flags;
  assign frameErrSyncSearchOut = s.flags.framingErr;
  assign frameErrSyncSearchOe = ~s.ctrl.rateModeSel[SYNC_MODE_BIT] & ~disableQ;
endmodule : sync_char_search_receiver

// ---- rx_search_chk.sv ----
// Port-level assertions for the character search receiver
module rx_search_chk (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic master_clear,
  input wire logic chip_disable,
  input wire logic rx_shift_clock,
  input wire logic char_received_clear_n,
  input wire logic frameErrSyncSearchOe,
  input wire logic [rx_pkg::DATA_W-1:0] holdData,
  input wire logic holdOutEnable,
  input wire rx_pkg::flags_t flags
);
  import rx_pkg::*;
  // ======
  // Cycles since last receive clock fall
  logic prevClk;
  logic [3:0] sinceFall;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      prevClk <= 1'b1;
      sinceFall <= 4'hF;
    end else begin
      prevClk <= rx_shift_clock;
      if (prevClk && !rx_shift_clock) begin
        sinceFall <= 4'h0;
      end else if (sinceFall != 4'hF) begin
        sinceFall <= sinceFall + 4'h1;
      end
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  // ======
  a_reset_idle: assert property ($rose(rstn) |->
    holdData == 8'hFF && flags == 5'h00) else $error("bad reset state");
  a_clear_idle: assert property (master_clear [*8] |->
    holdData == 8'hFF && flags == 5'h00) else $error("clear not idle");
  a_ovr_cause: assert property ($rose(flags.overrun) |->
    $past(flags.charReceived) && sinceFall <= 4'hA)
    else $error("overrun without pending char");
  a_recv_timing: assert property ($rose(flags.charReceived) |->
    sinceFall <= 4'hA) else $error("received away from bit");
  a_match_timing: assert property ($rose(flags.matchFound) |->
    sinceFall <= 4'hA) else $error("match away from bit");
  a_recv_clear: assert property
    ((!char_received_clear_n && !chip_disable) [*8] |->
    !flags.charReceived || sinceFall <= 4'hA) else $error("recv not cleared");
  a_cd_blocks: assert property (chip_disable [*8] |->
    !holdOutEnable && !frameErrSyncSearchOe) else $error("outputs not off");
  a_cd_enables: assert property ((!chip_disable) [*8] |->
    holdOutEnable) else $error("holding output off");
endmodule : rx_search_chk

bind sync_char_search_receiver rx_search_chk chk (.ref_clk, .rstn,
  .master_clear, .chip_disable, .rx_shift_clock, .char_received_clear_n,
  .frameErrSyncSearchOe, .holdData, .holdOutEnable, .flags);

// ---- rx_line_model.sv ----
// Serial sender with bit-centred receive clock
module rx_line_model (
  output logic rxClk,
  output logic rxData
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rxClk = 1'b1;
    rxData = 1'b1;
  end
  // Bits go LSB first, k falls per bit, clock still between frames
  task automatic send(input logic [7:0] bits, input int n, input int k);
    for (int i = 0; i < n; i++) begin
      rxData = bits[i];
      repeat (k) begin
        #60 rxClk = 1'b0;
        #60 rxClk = 1'b1;
      end
    end
    rxData = 1'b1;
  endtask : send
endmodule : rx_line_model

// ---- sync_char_search_receiver_tb.sv ----
// Self-checking bench for the character search receiver
module sync_char_search_receiver_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rx_pkg::*;
  logic ref_clk, rstn, masterClear, chipDisable, rxShiftClock, serialIn;
  logic ctrlLoadN, matchLoadN, recvClearN, statClearN, searchDrv;
  logic errOut, errOe, searchWire;
  ctrl_t ctrlIn;
  logic [7:0] matchIn, holdData;
  flags_t flags;
  int n_fail = 0;
  int n_tests = 0;
  typedef struct packed {logic [1:0] wl; logic [7:0] d; logic [7:0] q;} row_t;
  row_t rows [4] = '{'{2'h0, 8'hF5, 8'h15}, '{2'h1, 8'hEA, 8'h2A},
    '{2'h2, 8'hD5, 8'h55}, '{2'h3, 8'hC3, 8'hC3}};
  assign searchWire = errOe ? errOut : searchDrv;
  sync_char_search_receiver uut (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .master_clear(masterClear),
    .chip_disable(chipDisable),
    .rx_shift_clock(rxShiftClock),
    .serial_in(serialIn),
    .ctrl_load_strobe_n(ctrlLoadN),
    .ctrlIn(ctrlIn),
    .match_load_strobe_n(matchLoadN),
    .matchIn(matchIn),
    .char_received_clear_n(recvClearN),
    .status_flag_clear_n(statClearN),
    .frameErrSyncSearchIn(searchWire),
    .frameErrSyncSearchOut(errOut),
    .frameErrSyncSearchOe(errOe),
    .holdData(holdData),
    .holdOutEnable(),
    .flags(flags)
  );
  rx_line_model line (.rxClk(rxShiftClock), .rxData(serialIn));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // ======
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic set_ctrl(input ctrl_t c);
    ctrlIn = c;
    ctrlLoadN = 1'b0;
    cyc(6);
    ctrlLoadN = 1'b1;
    cyc(6);
  endtask : set_ctrl
  task automatic search(input logic lvl);
    searchDrv = lvl;
    cyc(8);
  endtask : search
  task automatic frame(input logic [7:0] d, input int n);
    line.send(d, n, 1);
    cyc(6);
  endtask : frame
  task automatic clear_flags;
    recvClearN = 1'b0;
    statClearN = 1'b0;
    cyc(10);
    recvClearN = 1'b1;
    statClearN = 1'b1;
    cyc(2);
  endtask : clear_flags
  task automatic complete_run;
    $display("checks %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run
  initial begin
    #200000;
    n_fail++;
    complete_run();
  end
  // ======
  initial begin
    {rstn, masterClear, chipDisable, searchDrv} = 4'h0;
    {ctrlLoadN, matchLoadN, recvClearN, statClearN} = 4'hF;
    ctrlIn = CTRL_RESET;
    matchIn = 8'h00;
    cyc(2);
    rstn = 1'b1;
    chk({holdData, flags}, {HOLD_RESET, FLAGS_RESET});
    foreach (rows[i]) begin
      set_ctrl({2'b01, 3'b101, rows[i].wl});
      search(1'b0);
      search(1'b1);
      frame(rows[i].d, 5 + rows[i].wl);
      chk({holdData, flags}, {rows[i].q, 5'h10});
      clear_flags();
    end
    frame(8'hA5, 8);
    frame(8'h3C, 8);
    chk({holdData, flags}, {8'h3C, 5'h11});
    clear_flags();
    chk({8'h00, flags}, 13'h0000);
    chipDisable = 1'b1;
    set_ctrl({2'b01, 3'b101, 2'b00});
    chipDisable = 1'b0;
    search(1'b0);
    search(1'b1);
    frame(8'hC3, 8);
    chk({holdData, flags}, {8'hC3, 5'h10});
    clear_flags();
    matchIn = 8'h96;
    matchLoadN = 1'b0;
    cyc(6);
    matchLoadN = 1'b1;
    set_ctrl({2'b01, 3'b100, 2'b11});
    search(1'b0);
    search(1'b1);
    frame(8'h96, 8);
    chk({8'h00, flags}, {8'h00, 5'h08});
    frame(8'h3C, 8);
    chk({holdData, flags}, {8'h3C, 5'h10});
    frame(8'h96, 8);
    chk({holdData, flags}, {8'h96, 5'h19});
    search(1'b0);
    frame(8'h5A, 8);
    chk({holdData, flags}, {8'h5A, 5'h19});
    masterClear = 1'b1;
    cyc(10);
    masterClear = 1'b0;
    cyc(6);
    chk({holdData, flags}, {8'hFF, 5'h00});
    search(1'b1);
    frame(8'h00, 8);
    chk({8'h00, flags}, {8'h00, 5'h08});
    // Asynchronous x1: even parity, five data bits
    set_ctrl({2'b10, 3'b000, 2'b00});
    line.send(8'h80, 8, 1);
    cyc(6);
    chk({holdData, flags}, {8'h00, 5'h18});
    line.send(8'h2C, 8, 1);
    cyc(6);
    chk({holdData, flags}, {8'h16, 5'h17});
    chk({11'h000, errOe, errOut}, 13'h0003);
    clear_flags();
    chk({11'h000, errOe, errOut}, 13'h0002);
    // Asynchronous x16: start checked mid bit
    set_ctrl({2'b10, 3'b001, 2'b00});
    line.send(8'h92, 8, 16);
    cyc(6);
    chk({holdData, flags}, {8'h09, 5'h10});
    complete_run();
  end
endmodule : sync_char_search_receiver_tb
